// *** hdl/dcr_consts.svh ***
`ifndef DCR_CONSTS_SVH
`define DCR_CONSTS_SVH
// register offsets
`define DCR_ADDR_LINK 8'h00
`define DCR_ADDR_IDENT 8'h01
`define DCR_ADDR_SPARE 8'h02
`define DCR_ADDR_SLEEP 8'h03
`define DCR_ADDR_CLEAR 8'h04
`define DCR_ADDR_OUTCFG 8'h05
`define DCR_ADDR_SOFTRST 8'h7f
// reset values
`define DCR_RST_LINK 16'h0000
`define DCR_RST_SPARE 16'h0000
`define DCR_RST_SLEEP 16'h0001
`define DCR_RST_CLEAR 16'h0000
`define DCR_RST_OUTCFG 16'h0003
// field positions
`define DCR_BIT_LINK_DIS 14
`define DCR_BIT_BUS_PASS 13
`define DCR_ADDR_MSB 4
`define DCR_BIT_MAN_SLEEP 1
`define DCR_BIT_AUTO_SLEEP 0
`define DCR_BIT_CLR_REQ 0
`define DCR_BIT_OUT1_MUTE 3
`define DCR_BIT_OUT0_MUTE 2
// soft reset codes
`define DCR_CODE_ASSERT 16'haa00
`define DCR_CODE_RELEASE 16'hdd00
`define DCR_CODE_PULSE 16'had00
`endif

// *** hdl/dcr_pkg.sv ***
package dcr_pkg;
  // soft reset sequencer states
  typedef enum logic [2:0] {
    RST_RELEASED = 3'b001,
    RST_HELD = 3'b010,
    RST_PULSE = 3'b100
  } dcr_rst_state_type;

  // complete block state
  typedef struct packed {
    logic [15:0] link_word;
    logic [15:0] spare_word;
    logic [15:0] sleep_word;
    logic [15:0] clear_word;
    logic [15:0] outcfg_word;
    logic [15:0] rdata;
    logic rd_valid;
    dcr_rst_state_type rst_state;
    logic [1:0] serial_ctrl_in_sync;
    logic [1:0] los_sync;
    logic serial_out;
    logic clr_status;
    logic clr_pulse;
    logic sleep;
    logic out0_mute;
    logic out0_pd;
    logic out1_mute;
    logic out1_pd;
    logic soft_rst;
  } dcr_state_type;
endpackage

// *** hdl/dcr_top.sv ***
// Operation
// - link disable 0 loops serial input to output; 1 holds output high
// - bus-through bit selects bus-through mode, resets to zero
// - five-bit unit address, reset zero, sets answering address
// - identification word is read-only; writes have no effect
// - soft reset returns all registers and control logic to defaults; read port and input synchronizers keep running
// - aa00 asserts soft reset, dd00 releases; register resets released
// - ad00 gives a single self-completing soft reset pulse
// - reset register reads aa00 while asserted, dd00 once released
// - auto sleep off: manual bit 0 awake, 1 asleep; resets zero
// - auto sleep on by default: sleep on loss of signal
// - clear request 1 clears sticky counts via four-phase handshake
// - sleep: driver one muted if bit set, else powered down
// - sleep: driver zero muted if bit set, else powered down
`timescale 1ns/10ps
`include "dcr_consts.svh"

module dcr_top #(
  parameter logic [15:0] IDENT_VALUE = 16'h5a01 // arbitrary value
) (
  input wire logic clk, // 40 MHz core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic reg_wr_en, // register write strobe
  input wire logic reg_rd_en, // register read strobe
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [15:0] reg_wdata, // write data
  output logic [15:0] reg_rdata, // read data, one cycle later
  output logic reg_rd_valid, // read data valid pulse
  input wire logic serial_ctrl_in, // serial control input pin
  output logic serial_ctrl_out, // serial control output pin
  input wire logic signal_lost, // loss of input signal
  output logic bus_pass_mode_enable, // bus-through mode
  output logic loop_through_disable, // loop-through disabled
  output logic [4:0] unit_bus_address, // device unit address
  output logic soft_reset_active, // soft reset in force
  output logic sticky_clear, // clear sticky counters pulse
  output logic clear_counts_status, // clear handshake status
  output logic sleep_active, // device asleep
  output logic driver_out_zero_mute, // driver zero muted
  output logic driver_out_zero_power_down, // driver zero powered down
  output logic driver_out_one_mute, // driver one muted
  output logic driver_out_one_power_down // driver one powered down
);

  dcr_pkg::dcr_state_type s_r;
  dcr_pkg::dcr_state_type s_nxt;

  // read decode of the register map
  function automatic logic [15:0] read_word(
    input logic [7:0] addr,
    input dcr_pkg::dcr_state_type s
  );
    logic [15:0] w;
    w = 16'h0000;
    unique case (addr)
      `DCR_ADDR_LINK: w = s.link_word;
      `DCR_ADDR_IDENT: w = IDENT_VALUE;
      `DCR_ADDR_SPARE: w = s.spare_word;
      `DCR_ADDR_SLEEP: w = s.sleep_word;
      `DCR_ADDR_CLEAR: w = s.clear_word;
      `DCR_ADDR_OUTCFG: w = s.outcfg_word;
      `DCR_ADDR_SOFTRST: w = (s.rst_state == dcr_pkg::RST_RELEASED) ?
                             `DCR_CODE_RELEASE : `DCR_CODE_ASSERT;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // write hit on one offset
  function automatic logic wr_hit(input logic [7:0] off);
    return reg_wr_en && (reg_addr == off);
  endfunction

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.serial_ctrl_in_sync = {s_r.serial_ctrl_in_sync[0], serial_ctrl_in};
    s_nxt.los_sync = {s_r.los_sync[0], signal_lost};
    // soft reset sequencer
    unique case (s_r.rst_state)
      dcr_pkg::RST_RELEASED, dcr_pkg::RST_HELD: begin
        if (wr_hit(`DCR_ADDR_SOFTRST)) begin
          if (reg_wdata == `DCR_CODE_ASSERT) begin
            s_nxt.rst_state = dcr_pkg::RST_HELD;
          end else if (reg_wdata == `DCR_CODE_RELEASE) begin
            s_nxt.rst_state = dcr_pkg::RST_RELEASED;
          end else if (reg_wdata == `DCR_CODE_PULSE) begin
            s_nxt.rst_state = dcr_pkg::RST_PULSE;
          end
        end
      end
      dcr_pkg::RST_PULSE: s_nxt.rst_state = dcr_pkg::RST_RELEASED;
      default: s_nxt.rst_state = dcr_pkg::RST_RELEASED;
    endcase
    s_nxt.soft_rst = (s_nxt.rst_state != dcr_pkg::RST_RELEASED);
    // register writes, id word has no storage
    // full sixteen-bit storage
    if (wr_hit(`DCR_ADDR_LINK)) s_nxt.link_word = reg_wdata;
    if (wr_hit(`DCR_ADDR_SPARE)) s_nxt.spare_word = reg_wdata;
    if (wr_hit(`DCR_ADDR_SLEEP)) s_nxt.sleep_word = reg_wdata;
    if (wr_hit(`DCR_ADDR_CLEAR)) s_nxt.clear_word = reg_wdata;
    if (wr_hit(`DCR_ADDR_OUTCFG)) s_nxt.outcfg_word = reg_wdata;
    // read port
    s_nxt.rd_valid = reg_rd_en;
    s_nxt.rdata = reg_rd_en ? read_word(reg_addr, s_r) : 16'h0000;
    s_nxt.serial_out = s_r.link_word[`DCR_BIT_LINK_DIS] ? 1'b1 :
                       s_r.serial_ctrl_in_sync[1];
    s_nxt.clr_pulse = s_r.clear_word[`DCR_BIT_CLR_REQ] && !s_r.clr_status
                      && !s_r.clr_pulse;
    s_nxt.clr_status = s_r.clear_word[`DCR_BIT_CLR_REQ] &&
                       (s_r.clr_status || s_r.clr_pulse);
    // auto sleep on loss of signal
    s_nxt.sleep = s_r.sleep_word[`DCR_BIT_AUTO_SLEEP] ? s_r.los_sync[1] :
                  s_r.sleep_word[`DCR_BIT_MAN_SLEEP];
    // driver one mute or power down
    s_nxt.out1_mute = s_r.sleep && s_r.outcfg_word[`DCR_BIT_OUT1_MUTE];
    s_nxt.out1_pd = s_r.sleep && !s_r.outcfg_word[`DCR_BIT_OUT1_MUTE];
    // driver zero mute or power down
    s_nxt.out0_mute = s_r.sleep && s_r.outcfg_word[`DCR_BIT_OUT0_MUTE];
    s_nxt.out0_pd = s_r.sleep && !s_r.outcfg_word[`DCR_BIT_OUT0_MUTE];
    // defaults while soft reset in force
    if (s_nxt.soft_rst) begin
      s_nxt.link_word = `DCR_RST_LINK;
      s_nxt.spare_word = `DCR_RST_SPARE;
      s_nxt.sleep_word = `DCR_RST_SLEEP;
      s_nxt.clear_word = `DCR_RST_CLEAR;
      s_nxt.outcfg_word = `DCR_RST_OUTCFG;
      s_nxt.serial_out = 1'b0;
      s_nxt.clr_pulse = 1'b0;
      s_nxt.clr_status = 1'b0;
      s_nxt.sleep = 1'b0;
      s_nxt.out0_mute = 1'b0;
      s_nxt.out0_pd = 1'b0;
      s_nxt.out1_mute = 1'b0;
      s_nxt.out1_pd = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.link_word <= `DCR_RST_LINK;
      s_r.spare_word <= `DCR_RST_SPARE;
      s_r.sleep_word <= `DCR_RST_SLEEP;
      s_r.clear_word <= `DCR_RST_CLEAR;
      s_r.outcfg_word <= `DCR_RST_OUTCFG;
      s_r.rst_state <= dcr_pkg::RST_RELEASED;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata = s_r.rdata;
  assign reg_rd_valid = s_r.rd_valid;
  assign serial_ctrl_out = s_r.serial_out;
  assign bus_pass_mode_enable = s_r.link_word[`DCR_BIT_BUS_PASS];
  assign loop_through_disable = s_r.link_word[`DCR_BIT_LINK_DIS];
  assign unit_bus_address = s_r.link_word[`DCR_ADDR_MSB:0];
  assign soft_reset_active = s_r.soft_rst;
  assign sticky_clear = s_r.clr_pulse;
  assign clear_counts_status = s_r.clr_status;
  assign sleep_active = s_r.sleep;
  assign driver_out_zero_mute = s_r.out0_mute;
  assign driver_out_zero_power_down = s_r.out0_pd;
  assign driver_out_one_mute = s_r.out1_mute;
  assign driver_out_one_power_down = s_r.out1_pd;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seq_pulse_write;
    reg_wr_en && reg_addr == `DCR_ADDR_SOFTRST &&
    reg_wdata == `DCR_CODE_PULSE && !s_r.soft_rst;
  endsequence
  sequence seq_pulse_done;
    soft_reset_active ##1 !soft_reset_active;
  endsequence
  sequence seq_clear_raise;
    s_r.clear_word[0] && !clear_counts_status && !sticky_clear &&
    !s_nxt.soft_rst;
  endsequence

  a_loop_held_high: assert property (
    loop_through_disable && !s_nxt.soft_rst |=> serial_ctrl_out)
    else $error("serial output not held high");
  a_loop_passes: assert property (
    !loop_through_disable && !s_nxt.soft_rst
    |=> serial_ctrl_out == $past(s_r.serial_ctrl_in_sync[1]))
    else $error("serial input not looped through");
  a_bus_pass_write: assert property (
    reg_wr_en && reg_addr == `DCR_ADDR_LINK && !s_nxt.soft_rst
    |=> bus_pass_mode_enable == $past(reg_wdata[13]) &&
        unit_bus_address == $past(reg_wdata[4:0]))
    else $error("bus-through or address not taken");
  a_ident_read: assert property (
    reg_rd_en && reg_addr == `DCR_ADDR_IDENT
    |=> reg_rd_valid && reg_rdata == IDENT_VALUE)
    else $error("identification word wrong");
  a_held_code: assert property (
    reg_rd_en && reg_addr == `DCR_ADDR_SOFTRST
    |=> reg_rdata == ($past(s_r.soft_rst) ?
        `DCR_CODE_ASSERT : `DCR_CODE_RELEASE))
    else $error("reset register read-back wrong");
  a_soft_defaults: assert property (
    soft_reset_active |-> s_r.link_word == `DCR_RST_LINK &&
    s_r.sleep_word == `DCR_RST_SLEEP && s_r.outcfg_word == `DCR_RST_OUTCFG
    && !sleep_active && !clear_counts_status)
    else $error("defaults not held in soft reset");
  a_pulse_self_end: assert property (
    seq_pulse_write |=> seq_pulse_done)
    else $error("soft reset pulse did not complete");
  a_sleep_select: assert property (
    !s_nxt.soft_rst |=> sleep_active == ($past(s_r.sleep_word[0]) ?
      $past(s_r.los_sync[1]) : $past(s_r.sleep_word[1])))
    else $error("sleep selection wrong");
  a_clear_hs: assert property (
    seq_clear_raise |=> sticky_clear ##1 clear_counts_status)
    else $error("clear handshake stalled");
  a_mute_select: assert property (
    sleep_active && !s_nxt.soft_rst |=> driver_out_one_mute ==
    $past(s_r.outcfg_word[3]) && driver_out_one_power_down ==
    !$past(s_r.outcfg_word[3]))
    else $error("driver one sleep action wrong");
  a_mute_zero: assert property (
    sleep_active && !s_nxt.soft_rst |=> driver_out_zero_mute ==
    $past(s_r.outcfg_word[2]) && driver_out_zero_power_down ==
    !$past(s_r.outcfg_word[2]))
    else $error("driver zero sleep action wrong");

endmodule

// *** testbench/dcr_host_model.sv ***
`timescale 1ns/10ps
module dcr_host_model (
  input wire logic clk, // core clock
  output logic wr_en, // write strobe
  output logic rd_en, // read strobe
  output logic [7:0] addr, // register offset
  output logic [15:0] wdata, // write data
  input wire logic [15:0] rdata, // read data
  input wire logic rd_valid, // read data valid
  input wire logic clr_status // clear handshake status
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
  end
  // one-cycle write, data scrambled after release
  // whole word written as given
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    wdata <= ~d;
  endtask
  // one-cycle read, answer taken a cycle on
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
    v = rd_valid;
  endtask
  task automatic clear_counts(output logic up, output logic dn);
    wr(8'h04, 16'h0001);
    for (int i = 0; i < 20 && clr_status !== 1'b1; i++) @(posedge clk);
    up = clr_status;
    wr(8'h04, 16'h0000);
    for (int i = 0; i < 20 && clr_status !== 1'b0; i++) @(posedge clk);
    dn = ~clr_status;
  endtask
endmodule

// *** testbench/test_device_control_registers.sv ***
`timescale 1ns/10ps
`include "dcr_consts.svh"
module test_device_control_registers;
  localparam logic [15:0] ID = 16'h3c07; // arbitrary value
  logic clk, rst, wr, rd, rv, sin, sout, lost, bpm, ltd, sra, sclr;
  logic cst, slp, d0m, d0p, d1m, d1p, up, dn, b;
  logic [7:0] addr;
  logic [15:0] wd, rdat, r;
  logic [4:0] ua;
  logic [3:0] h;
  logic [15:0] m [logic [7:0]];
  int num_errors, cmp_count, n_sr, n_clr, seed;
  dcr_top #(.IDENT_VALUE(ID)) DUT (.clk(clk), .rst(rst), .reg_wr_en(wr),
    .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat),
    .reg_rd_valid(rv), .serial_ctrl_in(sin), .serial_ctrl_out(sout),
    .signal_lost(lost), .bus_pass_mode_enable(bpm),
    .loop_through_disable(ltd), .unit_bus_address(ua),
    .soft_reset_active(sra), .sticky_clear(sclr),
    .clear_counts_status(cst), .sleep_active(slp),
    .driver_out_zero_mute(d0m), .driver_out_zero_power_down(d0p),
    .driver_out_one_mute(d1m), .driver_out_one_power_down(d1p));
  dcr_host_model host (.clk(clk), .wr_en(wr), .rd_en(rd), .addr(addr),
    .wdata(wd), .rdata(rdat), .rd_valid(rv), .clr_status(cst));
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // pulse counters for soft reset and clear
  always @(posedge clk) begin
    if (sra === 1'b1) n_sr = n_sr + 1;
    if (sclr === 1'b1) n_clr = n_clr + 1;
  end
  task automatic end_of_test;
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // model registers back to defaults
  function automatic void mdef();
    m[`DCR_ADDR_LINK] = `DCR_RST_LINK;
    m[`DCR_ADDR_IDENT] = ID;
    m[`DCR_ADDR_SPARE] = `DCR_RST_SPARE;
    m[`DCR_ADDR_SLEEP] = `DCR_RST_SLEEP;
    m[`DCR_ADDR_CLEAR] = `DCR_RST_CLEAR;
    m[`DCR_ADDR_OUTCFG] = `DCR_RST_OUTCFG;
    m[`DCR_ADDR_SOFTRST] = `DCR_CODE_RELEASE;
  endfunction
  task automatic rchk(input logic [7:0] a);
    logic [15:0] d;
    logic v;
    host.rd(a, d, v);
    chk("rd_valid", {15'h0, v}, 16'h0001);
    chk("rdata", d, m.exists(a) ? m[a] : 16'h0000);
  endtask
  task automatic mwr(input logic [7:0] a, input logic [15:0] d);
    host.wr(a, d);
    if (m.exists(a) && a != 8'h01 && a != 8'h7f) m[a] = d;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    {rst, sin, lost} = 3'b100;
    seed = 32'hac0c;
    {num_errors, cmp_count, n_sr, n_clr} = '0;
    h = 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    mdef();
    foreach (m[k]) rchk(k);
    for (int i = 0; i < 6; i++) begin
      r = 16'($random(seed)) & 16'h601f;
      mwr(8'h00, r);
      mwr(8'h01, 16'($random(seed)));
      mwr(8'h10, 16'($random(seed)));
      chk("link_dis", {15'h0, ltd}, {15'h0, r[14]});
      chk("bus_pass", {15'h0, bpm}, {15'h0, r[13]});
      chk("unit_addr", {11'h0, ua}, {11'h0, r[4:0]});
      rchk(8'h00);
      rchk(8'h01);
      rchk(8'h10);
    end
    // loop-through then held high
    for (int dis = 0; dis < 2; dis++) begin
      mwr(8'h00, dis ? 16'h4000 : 16'h0000);
      repeat (3) @(posedge clk);
      for (int i = 0; i < 30; i++) begin
        @(posedge clk);
        b = 1'($random(seed));
        sin <= b;
        h = {h[2:0], b};
        @(negedge clk);
        if (i > 2) chk("sout", {15'h0, sout}, {15'h0, dis ? 1'b1 : h[3]});
      end
    end
    // every sleep mode and driver choice
    for (int k = 0; k < 16; k++) begin
      r = {12'h0, k[3] ^ k[0], k[3], 2'b11};
      mwr(8'h05, r);
      mwr(8'h03, {14'h0, k[1], k[0]});
      lost <= k[2];
      repeat (6) @(posedge clk);
      @(negedge clk);
      b = k[0] ? k[2] : k[1];
      chk("sleep", {15'h0, slp}, {15'h0, b});
      chk("d1_mute", {15'h0, d1m}, {15'h0, b & r[3]});
      chk("d1_pd", {15'h0, d1p}, {15'h0, b & ~r[3]});
      chk("d0_mute", {15'h0, d0m}, {15'h0, b & r[2]});
      chk("d0_pd", {15'h0, d0p}, {15'h0, b & ~r[2]});
      rchk(8'h05);
    end
    n_clr = 0;
    host.clear_counts(up, dn);
    chk("clr_hs", {14'h0, up, dn}, 16'h0003);
    chk("clr_pulses", 16'(n_clr), 16'h0001);
    // held soft reset, then release
    mwr(8'h00, 16'h2005);
    host.wr(8'h7f, `DCR_CODE_ASSERT);
    mdef();
    m[8'h7f] = `DCR_CODE_ASSERT;
    @(negedge clk);
    chk("srst_on", {15'h0, sra}, 16'h0001);
    rchk(8'h7f);
    rchk(8'h00);
    host.wr(8'h7f, `DCR_CODE_RELEASE);
    m[8'h7f] = `DCR_CODE_RELEASE;
    @(negedge clk);
    chk("srst_off", {15'h0, sra}, 16'h0000);
    rchk(8'h7f);
    rchk(8'h03);
    mwr(8'h00, 16'h4003);
    @(negedge clk);
    n_sr = 0;
    host.wr(8'h7f, `DCR_CODE_PULSE);
    repeat (4) @(posedge clk);
    chk("srst_pulse", 16'(n_sr), 16'h0001);
    mdef();
    rchk(8'h00);
    rchk(8'h7f);
    end_of_test();
  end
endmodule
